// >>> hold_avg_pkg.sv
// shared constants and carrier types for the holdover averager and tuning limiter
package hold_avg_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int FTW_W = 48;
    localparam int EXP_W = 4;
    localparam int CNT_W = 17;
    localparam int ACC_W = 64;
    localparam int SHIFT_W = 5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    // half the system sample rate on a 48-bit tuning word
    localparam logic [FTW_W-1:0] FTW_UPPER_RST = 48'h8000_0000_0000;
    localparam logic [FTW_W-1:0] FTW_LOWER_RST = 48'h0000_0000_0000;
    localparam logic [FTW_W-1:0] FTW_ZERO = 48'h0000_0000_0000;
    localparam logic [ACC_W-1:0] ACC_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 17'h0_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 17'h0_0001;
    localparam logic [SHIFT_W-1:0] SHIFT_ONE = 5'h01;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic samplerEnable;
        logic averageSelect;
        logic [EXP_W-1:0] blockExponent;
    } sampler_cfg_type;

    typedef struct packed {
        logic load;
        logic [FTW_W-1:0] upper;
        logic [FTW_W-1:0] lower;
    } limit_cfg_type;

    typedef enum logic [0:0] {
        TRACK = 1'b0,
        HOLD = 1'b1
    } hold_state_type;

endpackage

// >>> avg_pipe.sv
// two-stage pipeline of completed block averages
`timescale 1ns/1ps
module avg_pipe
    import hold_avg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [FTW_W-1:0] din,
    output logic [FTW_W-1:0] lastStage,
    output logic lastValid
);

    logic [FTW_W-1:0] stage1_r;
    logic [FTW_W-1:0] stage1_nxt;
    logic [FTW_W-1:0] stage2_r;
    logic [FTW_W-1:0] stage2_nxt;
    logic [1:0] fill_r;
    logic [1:0] fill_nxt;

    always_comb
    begin
        stage1_nxt = stage1_r;
        stage2_nxt = stage2_r;
        fill_nxt = fill_r;
        if (push)
        begin
            stage1_nxt = din;
            stage2_nxt = stage1_r;
            fill_nxt = {fill_r[0], 1'b1};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1_r <= FTW_ZERO;
            stage2_r <= FTW_ZERO;
            fill_r <= 2'h0;
        end
        else
        begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
            fill_r <= fill_nxt;
        end
    end

    assign lastStage = stage2_r;
    assign lastValid = fill_r[1];

endmodule

// >>> holdover_averager_tuning_limiter.sv
// holdover sampler/averager with tuning-word limiter in front of the dds
//
// How it works
// R1: while samplerEnable is high every loop-filter sample is taken in the background; one arriving in the first cycle of a new averageSelect value is dropped.
// R2: the sampler output feeds the traceWord output and the holdover capture logic.
// R3: on holdover entry the dds word becomes the latest sampler value, or in averaging mode the pipeline's last stage when fresh.
// R4: with averageSelect low samples pass unchanged, one per loop-filter sample.
// R5: with averageSelect high, blocks of 2^(blockExponent+1) samples are averaged.
// R6: in averaging mode one result leaves per completed block.
// R7: each average enters a two-stage pipeline and holdover reads its last stage once it holds two fresh averages.
// R8: the pipeline holds each average back by one block period.
// R9: the tuning word is 48 bits spanning zero to half the sample rate.
// R10: the tuning word is clipped to the programmed upper and lower bounds.
// R11: after reset the bounds are half the sample rate and zero, so no clipping occurs.
// R12: software should narrow the bounds carefully since tight limits may destabilise the loop.
// R13: while holdover is asserted the dds gets the static held word, not the loop filter.
// R14: the accumulator restarts each block and the sum is divided by a right shift.
`timescale 1ns/1ps
module holdover_averager_tuning_limiter
    import hold_avg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sampler_cfg_type samplerCfg,
    input wire limit_cfg_type limitCfg,
    input wire logic [FTW_W-1:0] loopWord,
    input wire logic loopValid,
    input wire logic holdover,
    output logic [FTW_W-1:0] traceWord,
    output logic traceValid,
    output logic [FTW_W-1:0] ddsWord,
    output logic ddsValid,
    output logic holdActive,
    output logic [FTW_W-1:0] upperBound,
    output logic [FTW_W-1:0] lowerBound
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [SHIFT_W-1:0] blockShift(input logic [EXP_W-1:0] e);
        // five bits wide, so an exponent of fifteen still shifts by sixteen
        return SHIFT_W'(e) + SHIFT_ONE;
    endfunction

    function automatic logic [CNT_W-1:0] blockLast(input logic [EXP_W-1:0] e);
        logic [CNT_W-1:0] len;
        len = CNT_ONE << blockShift(e);
        return len - CNT_ONE;
    endfunction

    function automatic logic [FTW_W-1:0] clip(
        input logic [FTW_W-1:0] w,
        input logic [FTW_W-1:0] hi,
        input logic [FTW_W-1:0] lo
    );
        logic [FTW_W-1:0] r;
        r = w;
        if (w > hi)
        begin
            r = hi;
        end
        else if (w < lo)
        begin
            r = lo;
        end
        return r;
    endfunction

    // ****************************************************************
    // sampler / averager
    // ****************************************************************
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [FTW_W-1:0] traceWord_r;
    logic [FTW_W-1:0] traceWord_nxt;
    logic traceValid_r;
    logic traceValid_nxt;
    logic avgPush;
    logic [FTW_W-1:0] avgValue;
    logic [ACC_W-1:0] blockSum;
    logic [SHIFT_W-1:0] shiftBy;
    logic [FTW_W-1:0] pipeLast;
    logic pipeValid;
    logic modeAvg_r;
    logic modeAvg_nxt;
    logic restart;

    always_comb
    begin
        acc_nxt = acc_r;
        count_nxt = count_r;
        traceWord_nxt = traceWord_r;
        traceValid_nxt = 1'b0;
        avgPush = 1'b0;
        // block restarts on a mode change so a mixed block never completes
        modeAvg_nxt = samplerCfg.averageSelect;
        shiftBy = blockShift(samplerCfg.blockExponent);
        // first sample of a block replaces the sum [R14]
        blockSum = ((count_r == CNT_ZERO) ? ACC_ZERO : acc_r) + ACC_W'(loopWord);
        avgValue = FTW_W'(blockSum >> shiftBy); // [R14]
        restart = !samplerCfg.samplerEnable || (modeAvg_r != samplerCfg.averageSelect);
        if (restart)
        begin
            acc_nxt = ACC_ZERO;
            count_nxt = CNT_ZERO;
        end
        else if (loopValid) // [R1]
        begin
            if (!samplerCfg.averageSelect)
            begin
                traceWord_nxt = loopWord; // [R4]
                traceValid_nxt = 1'b1;
            end
            else if (count_r >= blockLast(samplerCfg.blockExponent)) // [R5]
            begin
                traceWord_nxt = avgValue; // [R6]
                traceValid_nxt = 1'b1;
                avgPush = 1'b1; // [R7]
                acc_nxt = ACC_ZERO;
                count_nxt = CNT_ZERO;
            end
            else
            begin
                acc_nxt = blockSum;
                count_nxt = count_r + CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_r <= ACC_ZERO;
            count_r <= CNT_ZERO;
            traceWord_r <= FTW_ZERO;
            traceValid_r <= 1'b0;
            modeAvg_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            count_r <= count_nxt;
            traceWord_r <= traceWord_nxt;
            traceValid_r <= traceValid_nxt;
            modeAvg_r <= modeAvg_nxt;
        end
    end

    // pipeline shifts once per block, so the last stage lags by one block [R8]
    avg_pipe avg_pipe_inst
    (
        .clk(clk),
        .rst(rst),
        .push(avgPush),
        .din(avgValue),
        .lastStage(pipeLast),
        .lastValid(pipeValid)
    );

    // ****************************************************************
    // pipeline freshness
    // ****************************************************************
    // averages left in the pipeline from before a restart are stale and are never taken from its last stage [R7]
    logic [1:0] fresh_r;
    logic [1:0] fresh_nxt;
    logic pipeFresh;

    always_comb
    begin
        fresh_nxt = fresh_r;
        if (restart)
        begin
            fresh_nxt = 2'h0;
        end
        else if (avgPush)
        begin
            fresh_nxt = {fresh_r[0], 1'b1};
        end
        pipeFresh = fresh_r[1] && pipeValid;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fresh_r <= 2'h0;
        end
        else
        begin
            fresh_r <= fresh_nxt;
        end
    end

    // ****************************************************************
    // tuning limits
    // ****************************************************************
    logic [FTW_W-1:0] upper_r;
    logic [FTW_W-1:0] upper_nxt;
    logic [FTW_W-1:0] lower_r;
    logic [FTW_W-1:0] lower_nxt;

    always_comb
    begin
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        // narrowing is software's responsibility; nothing here checks loop stability [R12]
        if (limitCfg.load)
        begin
            upper_nxt = limitCfg.upper;
            lower_nxt = limitCfg.lower;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            upper_r <= FTW_UPPER_RST; // [R11]
            lower_r <= FTW_LOWER_RST; // [R11]
        end
        else
        begin
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
        end
    end

    // ****************************************************************
    // holdover capture and dds word
    // ****************************************************************
    hold_state_type state_r;
    hold_state_type state_nxt;
    logic [FTW_W-1:0] held_r;
    logic [FTW_W-1:0] held_nxt;
    logic [FTW_W-1:0] ddsWord_r;
    logic [FTW_W-1:0] ddsWord_nxt;
    logic ddsValid_r;
    logic ddsValid_nxt;
    logic [FTW_W-1:0] holdSource;
    logic holdActive_r;
    logic holdActive_nxt;

    always_comb
    begin
        state_nxt = state_r;
        held_nxt = held_r;
        ddsWord_nxt = ddsWord_r;
        ddsValid_nxt = 1'b0;
        // averaging takes the settled last stage once two fresh averages exist, else the newest word; pass-through the newest sample [R3]
        holdSource = traceWord_r; // [R2]
        if (modeAvg_r && pipeFresh)
        begin
            holdSource = pipeLast; // [R7]
        end
        case (state_r)
            TRACK:
            begin
                if (holdover)
                begin
                    state_nxt = HOLD;
                    held_nxt = clip(holdSource, upper_r, lower_r); // [R3]
                    ddsWord_nxt = held_nxt;
                    ddsValid_nxt = 1'b1;
                end
                else if (loopValid)
                begin
                    ddsWord_nxt = clip(loopWord, upper_r, lower_r); // [R9] [R10]
                    ddsValid_nxt = 1'b1;
                end
            end
            HOLD:
            begin
                ddsWord_nxt = held_r; // [R13]
                if (!holdover)
                begin
                    state_nxt = TRACK;
                end
            end
            default:
            begin
                state_nxt = TRACK;
            end
        endcase
        // registered copy of the state so the flag leaves straight from a flop
        holdActive_nxt = (state_nxt == HOLD); // [R13]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= TRACK;
            held_r <= FTW_ZERO;
            ddsWord_r <= FTW_ZERO;
            ddsValid_r <= 1'b0;
            holdActive_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            held_r <= held_nxt;
            ddsWord_r <= ddsWord_nxt;
            ddsValid_r <= ddsValid_nxt;
            holdActive_r <= holdActive_nxt;
        end
    end

    assign traceWord = traceWord_r;
    assign traceValid = traceValid_r;
    assign ddsWord = ddsWord_r;
    assign ddsValid = ddsValid_r;
    assign holdActive = holdActive_r;
    assign upperBound = upper_r;
    assign lowerBound = lower_r;

endmodule

// >>> hold_avg_checker.sv
// port assertions for the holdover averager and tuning limiter
`timescale 1ns/1ps
module hold_avg_checker
    import hold_avg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sampler_cfg_type samplerCfg,
    input wire limit_cfg_type limitCfg,
    input wire logic [FTW_W-1:0] loopWord,
    input wire logic loopValid,
    input wire logic holdover,
    input wire logic [FTW_W-1:0] traceWord,
    input wire logic traceValid,
    input wire logic [FTW_W-1:0] ddsWord,
    input wire logic ddsValid,
    input wire logic holdActive,
    input wire logic [FTW_W-1:0] upperBound,
    input wire logic [FTW_W-1:0] lowerBound
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ************************************************
    // properties
    // ************************************************
    property p_rstBounds;
        $fell(rst) |-> upperBound == FTW_UPPER_RST && lowerBound == FTW_LOWER_RST;
    endproperty
    a_rstBounds: assert property (p_rstBounds) else $error("bounds wrong after reset");
    property p_load;
        limitCfg.load |=> upperBound == $past(limitCfg.upper)
            && lowerBound == $past(limitCfg.lower);
    endproperty
    a_load: assert property (p_load) else $error("bounds not loaded");
    property p_pass;
        loopValid && samplerCfg.samplerEnable && !samplerCfg.averageSelect
            && $stable(samplerCfg) |=> traceValid && traceWord == $past(loopWord);
    endproperty
    a_pass: assert property (p_pass) else $error("sample not passed through");
    property p_off;
        !samplerCfg.samplerEnable |=> !traceValid;
    endproperty
    a_off: assert property (p_off) else $error("output while sampler off");
    property p_avgGap;
        traceValid && samplerCfg.averageSelect && $stable(samplerCfg) |=> !traceValid;
    endproperty
    a_avgGap: assert property (p_avgGap) else $error("average outputs too close");
    property p_clip;
        loopValid && !holdover && !holdActive && !limitCfg.load |=> ddsValid
            && ddsWord == ($past(loopWord) > upperBound ? upperBound
            : ($past(loopWord) < lowerBound ? lowerBound : $past(loopWord)));
    endproperty
    a_clip: assert property (p_clip) else $error("tracking word not clipped");
    property p_holdEntry;
        holdover && !holdActive |=> holdActive && ddsValid;
    endproperty
    a_holdEntry: assert property (p_holdEntry) else $error("no hold entry word");
    property p_holdStatic;
        holdActive && holdover |=> holdActive && !ddsValid && $stable(ddsWord);
    endproperty
    a_holdStatic: assert property (p_holdStatic) else $error("held word moved");
endmodule

bind holdover_averager_tuning_limiter hold_avg_checker hold_avg_checker_inst (
    .clk(clk), .rst(rst), .samplerCfg(samplerCfg), .limitCfg(limitCfg),
    .loopWord(loopWord), .loopValid(loopValid), .holdover(holdover),
    .traceWord(traceWord), .traceValid(traceValid), .ddsWord(ddsWord),
    .ddsValid(ddsValid), .holdActive(holdActive), .upperBound(upperBound),
    .lowerBound(lowerBound));

// >>> loop_filter_model.sv
// behavioural loop filter and holdover control feeding the block
`timescale 1ns/1ps
module loop_filter_model
    import hold_avg_pkg::*;
(
    input wire logic clk,
    output logic [FTW_W-1:0] loopWord,
    output logic loopValid,
    output logic holdover
);
    initial
    begin
        loopWord = FTW_ZERO;
        loopValid = 1'b0;
        holdover = 1'b0;
    end
    // idle data toggles so a stale word never looks valid
    task automatic send(input logic [FTW_W-1:0] w, input int gap);
        @(posedge clk);
        loopValid <= 1'b1;
        loopWord <= w;
        repeat (gap)
        begin
            @(posedge clk);
            loopValid <= 1'b0;
            loopWord <= ~loopWord;
        end
    endtask
    task automatic setHold(input logic h);
        @(posedge clk);
        holdover <= h;
    endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the holdover averager and tuning limiter
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top
    import hold_avg_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sampler_cfg_type sCfg = '0;
    limit_cfg_type lCfg = '0;
    logic [FTW_W-1:0] loopWord, traceWord, ddsWord, upperBound, lowerBound;
    logic loopValid, holdover, traceValid, ddsValid, holdActive;
    logic [FTW_W-1:0] tq[$], dq[$];
    logic [FTW_W-1:0] up = FTW_UPPER_RST, lo = FTW_LOWER_RST, lastTr = FTW_ZERO;
    logic [FTW_W-1:0] avgNew, avgOld, e;
    logic [ACC_W-1:0] sum;
    int fails = 0, comparisons = 0, cnt = 0, nAvg = 0;
    logic inHold = 1'b0;
    logic [31:0] seed = 32'hd0a7_24bc;
    always #2 clk = ~clk;

    loop_filter_model loop_filter_model_inst (.clk(clk), .loopWord(loopWord),
        .loopValid(loopValid), .holdover(holdover));
    holdover_averager_tuning_limiter holdover_averager_tuning_limiter_inst (
        .clk(clk), .rst(rst), .samplerCfg(sCfg), .limitCfg(lCfg), .loopWord(loopWord),
        .loopValid(loopValid), .holdover(holdover), .traceWord(traceWord),
        .traceValid(traceValid), .ddsWord(ddsWord), .ddsValid(ddsValid),
        .holdActive(holdActive), .upperBound(upperBound), .lowerBound(lowerBound));

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [FTW_W-1:0] clip(input logic [FTW_W-1:0] w);
        return w > up ? up : (w < lo ? lo : w);
    endfunction
    function automatic logic [FTW_W-1:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return {seed[15:0], seed};
    endfunction
    task automatic sample(input logic [FTW_W-1:0] w, input int gap);
        if (sCfg.samplerEnable && !sCfg.averageSelect)
        begin
            tq.push_back(w);
            lastTr = w;
        end
        else if (sCfg.samplerEnable)
        begin
            sum += w;
            cnt++;
            if (cnt == 2 << sCfg.blockExponent)
            begin
                avgOld = avgNew;
                avgNew = FTW_W'(sum >> (sCfg.blockExponent + 1));
                tq.push_back(avgNew);
                lastTr = avgNew;
                nAvg++;
                sum = ACC_ZERO;
                cnt = 0;
            end
        end
        if (!inHold)
            dq.push_back(clip(w));
        loop_filter_model_inst.send(w, gap);
    endtask
    // an idle edge after the change keeps the first sample out of the switch cycle
    task automatic setMode(input logic en, input logic av, input logic [EXP_W-1:0] y);
        @(posedge clk);
        // only an enable or path change empties the held-average history
        if (en != sCfg.samplerEnable || av != sCfg.averageSelect)
            nAvg = 0;
        sCfg <= '{en, av, y};
        sum = ACC_ZERO;
        cnt = 0;
        @(posedge clk);
    endtask
    task automatic hold(input logic h);
        if (h)
            dq.push_back(clip(sCfg.averageSelect && nAvg >= 2 ? avgOld : lastTr));
        loop_filter_model_inst.setHold(h);
        repeat (2) @(posedge clk);
        `CHK(holdActive, h)
        inHold = h;
    endtask
    // narrow limits can upset the loop; the limit test still narrows the band to 1000_0000_0000..4000_0000_0000 to exercise clipping
    task automatic setLimits(input logic [FTW_W-1:0] u, input logic [FTW_W-1:0] l);
        @(posedge clk);
        lCfg <= '{1'b1, u, l};
        @(posedge clk);
        lCfg.load <= 1'b0;
        up = u;
        lo = l;
        @(posedge clk);
        `CHK(upperBound, u)
        `CHK(lowerBound, l)
    endtask
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ************************************************
    // monitor and sequence
    // ************************************************
    always @(posedge clk)
    begin
        if (!rst && traceValid === 1'b1)
        begin
            e = tq.size() > 0 ? tq.pop_front() : ~traceWord;
            `CHK(traceWord, e)
        end
        if (!rst && ddsValid === 1'b1)
        begin
            e = dq.size() > 0 ? dq.pop_front() : ~ddsWord;
            `CHK(ddsWord, e)
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        `CHK(upperBound, FTW_UPPER_RST)
        `CHK(lowerBound, FTW_LOWER_RST)
        `CHK(ddsWord, FTW_ZERO)
        rst <= 1'b0;
        setMode(1'b1, 1'b0, 4'h0);
        repeat (8) sample(rnd(), 0);
        sample(rnd(), 1);
        hold(1'b1);
        sample(rnd(), 1);
        hold(1'b0);
        $display("pass-through and hold test done");
        setMode(1'b0, 1'b0, 4'h0);
        repeat (3) sample(rnd(), 0);
        sample(rnd(), 2);
        $display("sampler off test done");
        for (int i = 0; i < 3; i++)
        begin
            setMode(1'b1, 1'b1, i == 0 ? 4'h0 : (i == 1 ? 4'h1 : 4'h3));
            repeat (3 * (2 << sCfg.blockExponent) - 1) sample(rnd(), 0);
            sample(rnd(), 1);
        end
        hold(1'b1);
        repeat (2) sample(rnd(), 1);
        hold(1'b0);
        $display("averaging and pipeline test done");
        setMode(1'b1, 1'b0, 4'h0);
        setLimits(48'h4000_0000_0000, 48'h1000_0000_0000);
        sample(48'h7fff_ffff_ffff, 0);
        sample(48'h0000_0000_0001, 0);
        sample(48'h4000_0000_0000, 0);
        sample(48'h1000_0000_0000, 0);
        repeat (6) sample(rnd(), 0);
        sample(48'h5000_0000_0000, 1);
        hold(1'b1);
        hold(1'b0);
        $display("limit test done");
        repeat (4) @(posedge clk);
        `CHK(tq.size(), 0)
        `CHK(dq.size(), 0)
        final_report();
    end
    // whole run is under 150 cycles; over thirty times that means a hang
    initial
    begin
        #(4 * 5000);
        fails++;
        final_report();
    end
endmodule
